// ---- hw/pbc_defs.vh ----
`ifndef PBC_DEFS_VH
`define PBC_DEFS_VH

// Counter geometry
`define PBC_WIDTH 4
`define PBC_ZERO 4'h0
`define PBC_ONE 4'h1
`define PBC_ALL_ONES 4'hf

// Register byte offsets
`define PBC_ADDR_W 4
`define PBC_OFF_STATUS 4'h0
`define PBC_OFF_CTRL 4'h4
`define PBC_OFF_LOAD 4'h8
`define PBC_OFF_WRAPS 4'hc

// Status fields
`define PBC_ST_COUNT_LSB 0
`define PBC_ST_TC_BIT 4
`define PBC_ST_ASYNC_BIT 5

// Control fields
`define PBC_CTRL_GATE_BIT 0
`define PBC_CTRL_CLEAR_BIT 1
`define PBC_CTRL_RESET 1'b1

// Wrap counter
`define PBC_WRAP_W 16
`define PBC_WRAP_ZERO 16'h0000
`define PBC_WRAP_ONE 16'h0001

`endif

// ---- hw/pbc_core.v ----
`timescale 1ns/1ps
`include "pbc_defs.vh"

module pbc_core #(
	parameter WIDTH = `PBC_WIDTH,
	parameter ASYNC_CLEAR = 1
) (
	input wire clk,
	input wire rst_b,
	input wire async_clear_n,
	input wire sync_clear,
	input wire load,
	input wire [WIDTH-1:0] load_value,
	input wire count_enable,
	output reg [WIDTH-1:0] count_q,
	output wire wrap
);

wire clear_async_b;
reg [WIDTH-1:0] count_d;

////////////////////////////////////////////////////////////////////////////////
// Asynchronous clear path, present only in the master-clear build
assign clear_async_b = rst_b & ((ASYNC_CLEAR != 0) ? async_clear_n : 1'b1);

// Step from all ones back to zero
assign wrap = count_enable & (&count_q);

////////////////////////////////////////////////////////////////////////////////
// Mode resolution: clear, then load, then count, then hold
always @* begin
	count_d = count_q;
	if (sync_clear) begin
		count_d = {WIDTH{1'b0}};
	end else if (load) begin
		count_d = load_value;
	end else if (count_enable) begin
		count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
	end
end

// All stages share the clock edge; inputs are only looked at here
always @(posedge clk or negedge clear_async_b) begin
	if (!clear_async_b) begin
		count_q <= {WIDTH{1'b0}};
	end else begin
		count_q <= count_d;
	end
end

endmodule

// ---- hw/pbc_counter.v ----
// Behaviour
// - Counts up in 4-bit binary; 15 steps to 0.
// - Count outputs change only on the rising clock edge, except async clear.
// - Priority: clear, then load, then count, then hold.
// - Async variant: low clear forces outputs low at once, overriding everything.
// - Sync variant: low clear zeroes outputs at next rising edge.
// - Low load copies preset inputs in at next edge, enables ignored.
// - Increments only when both count enables are high.
// - Either enable low holds the count.
// - Terminal count is trickle enable AND all four stages high.
// - Controls other than the async variant's clear are sampled only at the rising edge.
// - Cascade by feeding terminal count into the next stage enables, shared clock.
`timescale 1ns/1ps
`include "pbc_defs.vh"

module pbc_counter #(
	parameter WIDTH = `PBC_WIDTH,
	parameter ASYNC_CLEAR = 1
) (
	input wire clk,
	input wire rst_b,
	input wire async_clear_n,
	input wire sync_clear_n,
	input wire load_n,
	input wire count_enable_parallel,
	input wire count_enable_trickle,
	input wire [WIDTH-1:0] preset_in,
	output wire [WIDTH-1:0] count_out,
	output wire terminal_count,
	input wire [`PBC_ADDR_W-1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest
);

function pbc_hit;
	input [`PBC_ADDR_W-1:0] addr;
	input [`PBC_ADDR_W-1:0] offset;
	begin
		pbc_hit = (addr == offset);
	end
endfunction

reg gate_q;
reg gate_d;
reg sw_clear_q;
reg sw_clear_d;
reg sw_load_q;
reg sw_load_d;
reg [WIDTH-1:0] sw_value_q;
reg [WIDTH-1:0] sw_value_d;
reg [`PBC_WRAP_W-1:0] wraps_q;
reg [`PBC_WRAP_W-1:0] wraps_d;
reg [31:0] rdata_d;
wire [WIDTH-1:0] count_q;
wire wrap;
wire access;
wire commit_wr;
wire core_clear;
wire core_load;
wire [WIDTH-1:0] core_value;
wire core_enable;

////////////////////////////////////////////////////////////////////////////////
// Counter control
assign core_clear = ((ASYNC_CLEAR == 0) & ~sync_clear_n) | sw_clear_q;
assign core_load = ~load_n | sw_load_q;
assign core_value = ~load_n ? preset_in : sw_value_q;
assign core_enable = count_enable_parallel & count_enable_trickle & gate_q;

pbc_core #(
	.WIDTH(WIDTH),
	.ASYNC_CLEAR(ASYNC_CLEAR)
) u_core (
	.clk(clk),
	.rst_b(rst_b),
	.async_clear_n(async_clear_n),
	.sync_clear(core_clear),
	.load(core_load),
	.load_value(core_value),
	.count_enable(core_enable),
	.count_q(count_q),
	.wrap(wrap)
);

assign count_out = count_q;
// Decoded carry for cascading; combinational so the next stage sees it this cycle
assign terminal_count = count_enable_trickle & (&count_q);

////////////////////////////////////////////////////////////////////////////////
// Avalon slave: one wait cycle, then the request completes
assign access = avs_read | avs_write;
assign commit_wr = avs_write & ~avs_waitrequest;

always @* begin
	gate_d = gate_q;
	sw_clear_d = 1'b0;
	sw_load_d = 1'b0;
	sw_value_d = sw_value_q;
	wraps_d = wraps_q;
	if (wrap && !core_clear && !core_load) begin
		wraps_d = wraps_q + `PBC_WRAP_ONE;
	end
	if (commit_wr && avs_byteenable[0]) begin
		if (pbc_hit(avs_address, `PBC_OFF_CTRL)) begin
			gate_d = avs_writedata[`PBC_CTRL_GATE_BIT];
			sw_clear_d = avs_writedata[`PBC_CTRL_CLEAR_BIT];
		end
		if (pbc_hit(avs_address, `PBC_OFF_LOAD)) begin
			sw_value_d = avs_writedata[WIDTH-1:0];
			sw_load_d = 1'b1;
		end
		if (pbc_hit(avs_address, `PBC_OFF_WRAPS)) begin
			// A wrap in the clearing cycle still counts
			wraps_d = (wrap && !core_clear && !core_load) ? `PBC_WRAP_ONE : `PBC_WRAP_ZERO;
		end
	end
end

always @* begin
	rdata_d = 32'h0000_0000;
	if (pbc_hit(avs_address, `PBC_OFF_STATUS)) begin
		rdata_d[`PBC_ST_COUNT_LSB +: WIDTH] = count_q;
		rdata_d[`PBC_ST_TC_BIT] = terminal_count;
		rdata_d[`PBC_ST_ASYNC_BIT] = (ASYNC_CLEAR != 0);
	end else if (pbc_hit(avs_address, `PBC_OFF_CTRL)) begin
		rdata_d[`PBC_CTRL_GATE_BIT] = gate_q;
	end else if (pbc_hit(avs_address, `PBC_OFF_LOAD)) begin
		rdata_d[WIDTH-1:0] = sw_value_q;
	end else if (pbc_hit(avs_address, `PBC_OFF_WRAPS)) begin
		rdata_d[`PBC_WRAP_W-1:0] = wraps_q;
	end
end

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		gate_q <= `PBC_CTRL_RESET;
		sw_clear_q <= 1'b0;
		sw_load_q <= 1'b0;
		sw_value_q <= `PBC_ZERO;
		wraps_q <= `PBC_WRAP_ZERO;
		avs_readdata <= 32'h0000_0000;
		avs_waitrequest <= 1'b1;
	end else begin
		gate_q <= gate_d;
		sw_clear_q <= sw_clear_d;
		sw_load_q <= sw_load_d;
		sw_value_q <= sw_value_d;
		wraps_q <= wraps_d;
		avs_waitrequest <= ~(access & avs_waitrequest);
		if (avs_read && avs_waitrequest) begin
			avs_readdata <= rdata_d;
		end
	end
end

endmodule

// ---- tb/pbc_properties.sv ----
`timescale 1ns/1ps
module pbc_checker #(parameter ASYNC_CLEAR = 1) (
	input wire clk,
	input wire rst_b,
	input wire async_clear_n,
	input wire sync_clear_n,
	input wire load_n,
	input wire avs_write,
	input wire avs_waitrequest,
	input wire count_enable_parallel,
	input wire count_enable_trickle,
	input wire terminal_count,
	input wire [3:0] preset_in,
	input wire [3:0] count_out,
	input wire [3:0] avs_address,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_writedata
);
	reg gate_q, sw_q;
	reg [3:0] low_q;
	wire sw = avs_write && !avs_waitrequest;
	// Register side effects land one edge after the write
	wire q = async_clear_n && sync_clear_n && !sw_q;
	wire run = q && load_n && count_enable_parallel && count_enable_trickle && gate_q;
	// Master-clear build: a clear raised mid-cycle overrides whatever the edge did
	wire aclr = (ASYNC_CLEAR != 0) && !async_clear_n;
	always @(posedge clk or negedge rst_b)
		if (!rst_b) gate_q <= 1'b1;
		else if (sw && avs_byteenable[0] && avs_address == 4'h4) gate_q <= avs_writedata[0];
	always @(posedge clk) sw_q <= sw;
	always @(negedge clk) low_q <= count_out;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence top; run && &count_out; endsequence
	tc_rule_a: assert property (terminal_count == (count_enable_trickle && &count_out))
		else $error("tc");
	async_zero_a: assert property (ASYNC_CLEAR != 0 && !async_clear_n |-> !count_out)
		else $error("clear");
	sync_zero_a: assert property (ASYNC_CLEAR == 0 && !sync_clear_n |=> !count_out)
		else $error("clear");
	load_take_a: assert property (q && !load_n |=> aclr || count_out == $past(preset_in))
		else $error("load");
	count_step_a: assert property (run |=> aclr || count_out == $past(count_out) + 4'h1)
		else $error("count");
	wrap_zero_a: assert property (top |=> !count_out)
		else $error("wrap");
	hold_still_a: assert property (q && load_n && !run |=> aclr || $stable(count_out))
		else $error("hold");
	edge_only_a: assert property (async_clear_n |-> count_out == low_q)
		else $error("moved");
endmodule
bind pbc_counter pbc_checker #(.ASYNC_CLEAR(ASYNC_CLEAR)) i_chk (
	.clk(clk),
	.rst_b(rst_b),
	.async_clear_n(async_clear_n),
	.sync_clear_n(sync_clear_n),
	.load_n(load_n),
	.avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest),
	.count_enable_parallel(count_enable_parallel),
	.count_enable_trickle(count_enable_trickle),
	.terminal_count(terminal_count),
	.preset_in(preset_in),
	.count_out(count_out),
	.avs_address(avs_address),
	.avs_byteenable(avs_byteenable),
	.avs_writedata(avs_writedata)
);

// ---- tb/pbc_next_stage.sv ----
`timescale 1ns/1ps
module pbc_next_stage (
	input wire clk,
	input wire rst_b,
	input wire carry_in,
	input wire enable,
	output reg [3:0] upper_q
);
	// Carry only enables this stage on the shared clock
	always @(posedge clk or negedge rst_b)
		if (!rst_b) upper_q <= 4'h0;
		else if (carry_in && enable) upper_q <= upper_q + 4'h1;
endmodule

// ---- tb/pbc_counter_tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %0t mismatch got %h expected %h", $time, g, e); end end
module pbc_counter_tb;
	reg clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0;
	reg [3:0] c = 4'hc, pin = 4'h0, a = 4'h0;
	reg [31:0] wd = 32'h0, q;
	wire [31:0] rdata [2];
	wire [3:0] cnt [2];
	wire [3:0] hi;
	wire [1:0] tc, wt;
	integer n_errors = 0, n_compared = 0;
	always #25 clk = ~clk;
	// c is {clear_n, load_n, cep, cet}; instance 0 async clear, 1 sync clear
	for (genvar g = 0; g < 2; g++) begin : g_dut
		pbc_counter #(.ASYNC_CLEAR(1 - g)) i_dut (.clk(clk), .rst_b(rst_b),
			.async_clear_n(c[3]), .sync_clear_n(c[3]), .load_n(c[2]),
			.count_enable_parallel(c[1]), .count_enable_trickle(c[0]), .preset_in(pin),
			.count_out(cnt[g]), .terminal_count(tc[g]), .avs_address(a), .avs_read(rd),
			.avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
			.avs_readdata(rdata[g]), .avs_waitrequest(wt[g]));
	end
	pbc_next_stage i_next (.clk(clk), .rst_b(rst_b), .carry_in(tc[0]), .enable(c[1]),
		.upper_q(hi));
	// Expected value is what the previous call's controls produce
	task op(input [3:0] n, input [3:0] p, input [3:0] e);
		begin
			@(posedge clk);
			c <= n;
			pin <= p;
			@(negedge clk);
			`CHK(cnt[0], e)
			`CHK(cnt[1], e)
			`CHK(tc[0], n[0] && e == 4'hf)
			`CHK(tc[1], n[0] && e == 4'hf)
		end
	endtask
	task bus(input w, input [3:0] ad, input [31:0] d);
		begin
			@(posedge clk);
			rd <= !w;
			wr <= w;
			a <= ad;
			wd <= d;
			@(posedge clk);
			while (wt[0] !== 1'b0) @(posedge clk);
			q = rdata[0];
			rd <= 1'b0;
			wr <= 1'b0;
		end
	endtask
	task tally_and_finish;
		begin
			if (n_errors == 0 && n_compared > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	initial begin
		#20000;
		n_errors++;
		tally_and_finish;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		op(4'h8, 4'he, 4'h0);
		op(4'hf, 4'h0, 4'he);
		op(4'hf, 4'h0, 4'hf);
		op(4'hd, 4'h0, 4'h0);
		op(4'he, 4'h0, 4'h0);
		op(4'hb, 4'hf, 4'h0);
		op(4'hd, 4'h0, 4'hf);
		op(4'he, 4'h0, 4'hf);
		op(4'hf, 4'h0, 4'hf);
		op(4'hb, 4'h9, 4'h0);
		// Clear lands on a loaded 9: async build drops at once, sync build waits
		@(posedge clk);
		c <= 4'h3;
		@(negedge clk);
		`CHK(cnt[0], 4'h0)
		`CHK(cnt[1], 4'h9)
		op(4'hc, 4'h0, 4'h0);
		`CHK(hi, 4'h2)
		bus(1'b0, 4'h0, 32'h0);
		`CHK(q, 32'h20)
		`CHK(rdata[1], 32'h0)
		bus(1'b0, 4'hc, 32'h0);
		`CHK(q, 32'h2)
		bus(1'b1, 4'h8, 32'h5);
		op(4'hc, 4'h0, 4'h5);
		// Soft clear, then the gate off must hold the count with both enables high
		bus(1'b1, 4'h4, 32'h2);
		op(4'hf, 4'h0, 4'h0);
		op(4'hf, 4'h0, 4'h0);
		bus(1'b0, 4'h4, 32'h0);
		`CHK(q, 32'h0)
		bus(1'b0, 4'h2, 32'h0);
		`CHK(q, 32'h0)
		tally_and_finish;
	end
endmodule
